/* ppfs_map.vh */
// Pin function codes and analog channel codes for the port pin function select block
`ifndef PPFS_MAP_VH
`define PPFS_MAP_VH

// ----------------------------------------
// Pin function codes
// ----------------------------------------
`define PPFS_FN_W 3
`define PPFS_FN_IN 3'h0
`define PPFS_FN_OUT 3'h1
`define PPFS_FN_PERIPH_OUT 3'h2
`define PPFS_FN_PERIPH_IN 3'h3
`define PPFS_FN_BIDIR 3'h4
`define PPFS_FN_PROHIBITED 3'h5

// ----------------------------------------
// Analog channel codes
// ----------------------------------------
`define PPFS_CH_W 4
`define PPFS_CH_AN2 4'h6
`define PPFS_CH_AN1 4'h5
`define PPFS_CH_AN0 4'h4

`endif

/* ppfs_top.v */
// Port pin function select: decodes control bits into per-pin functions
`timescale 1ns/1ps
`include "ppfs_map.vh"
module ppfs_top (
    input wire clk_i,
    input wire reset_n_i,
    input wire iic_bus_enable_i,
    input wire serial2_tx_select_i,
    input wire rx_enable_bit_i,
    input wire clock_out_select_i,
    input wire serial_clk_ext_i,
    input wire serial_clk_int_i,
    input wire sync_mode_bit_i,
    input wire p3_bit2_dir_i,
    input wire p3_bit1_dir_i,
    input wire p3_bit0_dir_i,
    input wire ext_int4_select_i,
    input wire p9_bit2_dir_i,
    input wire ext_int3_select_i,
    input wire ext_int1_select_i,
    input wire ext_int0_select_i,
    input wire [3:0] adc_channel_field_i,
    output reg [2:0] p3_pin2_fn_o,
    output reg [2:0] p3_pin1_fn_o,
    output reg [2:0] p3_pin0_fn_o,
    output reg [2:0] p9_pin2_fn_o,
    output reg [2:0] portb_pin2_fn_o,
    output reg [2:0] portb_pin1_fn_o,
    output reg [2:0] portb_pin0_fn_o
);

    // ----------------------------------------
    // Local constants
    // ----------------------------------------
    localparam PB_PINS = 3; // Analog-capable port B pins

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Port direction bit to function code
    function [2:0] ppfs_dir;
        input dir; // Direction bit, 1 = output
        begin
            if (dir) begin
                ppfs_dir = `PPFS_FN_OUT; // Port output
            end else begin
                ppfs_dir = `PPFS_FN_IN; // Port input
            end
        end
    endfunction

    // Port B pin: interrupt, analog channel match or plain input
    // Interrupt and analog input share one code: both are peripheral inputs
    function [2:0] ppfs_pb;
        input irq_sel; // Interrupt select of this pin
        input [3:0] ch; // Current analog channel code
        input [3:0] code; // Channel code owned by this pin
        begin
            if (irq_sel) begin
                ppfs_pb = `PPFS_FN_PERIPH_IN; // Interrupt input wins
            end else if (ch == code) begin
                ppfs_pb = `PPFS_FN_PERIPH_IN; // Analog input
            end else begin
                ppfs_pb = `PPFS_FN_IN; // Plain port input
            end
        end
    endfunction

    // ----------------------------------------
    // Next-value signals
    // ----------------------------------------
    reg [2:0] next_p3_pin2; // Decoded port 3 pin 2
    reg [2:0] next_p3_pin1; // Decoded port 3 pin 1
    reg [2:0] next_p3_pin0; // Decoded port 3 pin 0
    reg [2:0] next_p9_pin2; // Decoded port 9 pin 2
    wire [PB_PINS-1:0] pb_irq_sel; // Port B interrupt selects, index = pin
    wire [4*PB_PINS-1:0] pb_code; // Channel code owned by each port B pin
    wire [3*PB_PINS-1:0] next_pb; // Decoded port B pins, three bits each

    // ----------------------------------------
    // Port 3 pin 2 decode
    // ----------------------------------------
    // I2C clock line over serial transmit over plain port
    always @* begin
        if (iic_bus_enable_i) begin
            // I2C owns the line in both directions
            next_p3_pin2 = `PPFS_FN_BIDIR;
        end else if (serial2_tx_select_i) begin
            // Serial transmit output
            next_p3_pin2 = `PPFS_FN_PERIPH_OUT;
        end else begin
            // Plain port, direction bit decides
            next_p3_pin2 = ppfs_dir(p3_bit2_dir_i);
        end
    end

    // ----------------------------------------
    // Port 3 pin 1 decode
    // ----------------------------------------
    // I2C data line over serial receive over plain port
    always @* begin
        if (iic_bus_enable_i) begin
            // I2C owns the line in both directions
            next_p3_pin1 = `PPFS_FN_BIDIR;
        end else if (rx_enable_bit_i) begin
            // Serial receive input
            next_p3_pin1 = `PPFS_FN_PERIPH_IN;
        end else begin
            // Plain port, direction bit decides
            next_p3_pin1 = ppfs_dir(p3_bit1_dir_i);
        end
    end

    // ----------------------------------------
    // Port 3 pin 0 decode
    // ----------------------------------------
    // Timer clock out over serial clock over plain port
    // External serial clock wins over internal clock or sync mode
    always @* begin
        if (clock_out_select_i) begin
            // Timer clock output
            next_p3_pin0 = `PPFS_FN_PERIPH_OUT;
        end else if (serial_clk_ext_i) begin
            // Serial clock taken from outside
            next_p3_pin0 = `PPFS_FN_PERIPH_IN;
        end else if (serial_clk_int_i || sync_mode_bit_i) begin
            // Serial clock driven from inside
            next_p3_pin0 = `PPFS_FN_PERIPH_OUT;
        end else begin
            // Plain port, direction bit decides
            next_p3_pin0 = ppfs_dir(p3_bit0_dir_i);
        end
    end

    // ----------------------------------------
    // Port 9 pin 2 decode
    // ----------------------------------------
    // Interrupt 4 input, plain port, or a flagged prohibited setting
    // The prohibited code lets the far side see a bad setting one clock after it is set
    always @* begin
        if (ext_int4_select_i && p9_bit2_dir_i) begin
            // Interrupt with output direction: not allowed
            next_p9_pin2 = `PPFS_FN_PROHIBITED;
        end else if (ext_int4_select_i) begin
            // Interrupt 4 input
            next_p9_pin2 = `PPFS_FN_PERIPH_IN;
        end else begin
            // Plain port, direction bit decides
            next_p9_pin2 = ppfs_dir(p9_bit2_dir_i);
        end
    end

    // ----------------------------------------
    // Port B decode
    // ----------------------------------------
    // Selects and owned channel codes gathered by pin index
    assign pb_irq_sel = {ext_int3_select_i, ext_int1_select_i, ext_int0_select_i};
    assign pb_code = {`PPFS_CH_AN2, `PPFS_CH_AN1, `PPFS_CH_AN0};

    // Same decode for every analog-capable pin
    genvar pb_idx;
    generate
        for (pb_idx = 0; pb_idx < PB_PINS; pb_idx = pb_idx + 1) begin : pb_dec
            assign next_pb[3*pb_idx+2:3*pb_idx] = ppfs_pb(pb_irq_sel[pb_idx],
                adc_channel_field_i, pb_code[4*pb_idx+3:4*pb_idx]);
        end
    endgenerate

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    // Codes follow the selects one clock later, with no further sequencing;
    // the register keeps every output on a flip-flop at the cost of that cycle
    // Port 3 pin function registers
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Reset: every pin a plain port input
            p3_pin2_fn_o <= `PPFS_FN_IN;
            p3_pin1_fn_o <= `PPFS_FN_IN;
            p3_pin0_fn_o <= `PPFS_FN_IN;
        end else begin
            // Load the current decode
            p3_pin2_fn_o <= next_p3_pin2;
            p3_pin1_fn_o <= next_p3_pin1;
            p3_pin0_fn_o <= next_p3_pin0;
        end
    end

    // Port 9 pin function register
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Reset: plain port input
            p9_pin2_fn_o <= `PPFS_FN_IN;
        end else begin
            // Load the current decode
            p9_pin2_fn_o <= next_p9_pin2;
        end
    end

    // Port B pin function registers
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Reset: every pin a plain port input
            portb_pin2_fn_o <= `PPFS_FN_IN;
            portb_pin1_fn_o <= `PPFS_FN_IN;
            portb_pin0_fn_o <= `PPFS_FN_IN;
        end else begin
            // Load the current decode, one slice per pin
            portb_pin2_fn_o <= next_pb[8:6];
            portb_pin1_fn_o <= next_pb[5:3];
            portb_pin0_fn_o <= next_pb[2:0];
        end
    end

endmodule // ppfs_top

/* ppfs_ext.sv */
// Model of the external circuitry hanging on a port pin
`timescale 1ns/1ps
module ppfs_ext (
    input wire [20:0] fn_i,
    output wire [6:0] ext_drive_o
);
    genvar k;
    generate
        for (k = 0; k < 7; k = k + 1) begin : pin
            // Outside world drives a pin while it is an input or an I2C line
            assign ext_drive_o[k] = (fn_i[3*k+2:3*k] == 3'h0) || (fn_i[3*k+2:3*k] == 3'h3)
                || (fn_i[3*k+2:3*k] == 3'h4);
        end
    endgenerate
endmodule // ppfs_ext

/* ppfs_top_asserts.sv */
// Checker for the port pin function select block
`timescale 1ns/1ps
module ppfs_chk (
    input wire clk_i,
    input wire reset_n_i,
    input wire iic_bus_enable_i,
    input wire serial2_tx_select_i,
    input wire rx_enable_bit_i,
    input wire clock_out_select_i,
    input wire serial_clk_ext_i,
    input wire ext_int4_select_i,
    input wire p9_bit2_dir_i,
    input wire ext_int3_select_i,
    input wire ext_int1_select_i,
    input wire ext_int0_select_i,
    input wire [3:0] adc_channel_field_i,
    input wire [2:0] p3_pin2_fn_o,
    input wire [2:0] p3_pin1_fn_o,
    input wire [2:0] p3_pin0_fn_o,
    input wire [2:0] p9_pin2_fn_o,
    input wire [2:0] portb_pin2_fn_o,
    input wire [2:0] portb_pin1_fn_o,
    input wire [2:0] portb_pin0_fn_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_SCL: assert property (
        iic_bus_enable_i |=> p3_pin2_fn_o == 3'h4) else $error("scl");
    AST_TX: assert property (
        !iic_bus_enable_i && serial2_tx_select_i |=> p3_pin2_fn_o == 3'h2) else $error("tx");
    AST_SDA: assert property (
        iic_bus_enable_i |=> p3_pin1_fn_o == 3'h4) else $error("sda");
    AST_RX: assert property (
        !iic_bus_enable_i && rx_enable_bit_i |=> p3_pin1_fn_o == 3'h3) else $error("rx");
    AST_CKO: assert property (
        clock_out_select_i |=> p3_pin0_fn_o == 3'h2) else $error("cko");
    AST_SCKI: assert property (
        !clock_out_select_i && serial_clk_ext_i |=> p3_pin0_fn_o == 3'h3) else $error("scki");
    AST_BAD: assert property (
        ext_int4_select_i && p9_bit2_dir_i |=> p9_pin2_fn_o == 3'h5) else $error("p9");
    AST_EXT_INT4_SELECT: assert property (
        ext_int4_select_i && !p9_bit2_dir_i |=> p9_pin2_fn_o == 3'h3) else $error("ext_int4_select");
    AST_AN2: assert property (
        portb_pin2_fn_o == 3'h3 |->
        $past(ext_int3_select_i) || $past(adc_channel_field_i) == 4'h6) else $error("pb2");
    AST_AN1: assert property (
        !ext_int1_select_i && adc_channel_field_i == 4'h5 |=>
        portb_pin1_fn_o == 3'h3) else $error("pb1");
    AST_PB0: assert property (
        !ext_int0_select_i && adc_channel_field_i != 4'h4 |=>
        portb_pin0_fn_o == 3'h0) else $error("pb0");
endmodule // ppfs_chk
bind ppfs_top ppfs_chk chk_u (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .iic_bus_enable_i(iic_bus_enable_i),
    .serial2_tx_select_i(serial2_tx_select_i),
    .rx_enable_bit_i(rx_enable_bit_i),
    .clock_out_select_i(clock_out_select_i),
    .serial_clk_ext_i(serial_clk_ext_i),
    .ext_int4_select_i(ext_int4_select_i),
    .p9_bit2_dir_i(p9_bit2_dir_i),
    .ext_int3_select_i(ext_int3_select_i),
    .ext_int1_select_i(ext_int1_select_i),
    .ext_int0_select_i(ext_int0_select_i),
    .adc_channel_field_i(adc_channel_field_i),
    .p3_pin2_fn_o(p3_pin2_fn_o),
    .p3_pin1_fn_o(p3_pin1_fn_o),
    .p3_pin0_fn_o(p3_pin0_fn_o),
    .p9_pin2_fn_o(p9_pin2_fn_o),
    .portb_pin2_fn_o(portb_pin2_fn_o),
    .portb_pin1_fn_o(portb_pin1_fn_o),
    .portb_pin0_fn_o(portb_pin0_fn_o)
);

/* ppfs_top_tb.sv */
// Self-checking bench for the port pin function select block
`timescale 1ns/1ps
module ppfs_top_tb;
    reg clk_i = 0;
    reg reset_n = 0;
    reg [18:0] v = 0; // All select inputs in one vector
    wire [20:0] o; // All function codes
    wire [6:0] ext; // Far side drive, one bit per pin
    reg [31:0] rnd = 0; // Raw random word
    integer err_count = 0;
    integer num_checks = 0;
    initial forever #12.5 clk_i = ~clk_i;
    ppfs_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n), .iic_bus_enable_i(v[18]),
        .serial2_tx_select_i(v[17]), .rx_enable_bit_i(v[16]), .clock_out_select_i(v[15]),
        .serial_clk_ext_i(v[14]), .serial_clk_int_i(v[13]), .sync_mode_bit_i(v[12]),
        .p3_bit2_dir_i(v[11]), .p3_bit1_dir_i(v[10]), .p3_bit0_dir_i(v[9]),
        .ext_int4_select_i(v[8]), .p9_bit2_dir_i(v[7]), .ext_int3_select_i(v[6]),
        .ext_int1_select_i(v[5]), .ext_int0_select_i(v[4]), .adc_channel_field_i(v[3:0]),
        .p3_pin2_fn_o(o[20:18]), .p3_pin1_fn_o(o[17:15]), .p3_pin0_fn_o(o[14:12]),
        .p9_pin2_fn_o(o[11:9]), .portb_pin2_fn_o(o[8:6]), .portb_pin1_fn_o(o[5:3]),
        .portb_pin0_fn_o(o[2:0]));
    ppfs_ext ext_u (.fn_i(o), .ext_drive_o(ext));
    // Port B pin: interrupt or matching channel gives peripheral input
    function [2:0] pb(input s, input [3:0] ch, input [3:0] c);
        pb = (s || ch == c) ? 3'h3 : 3'h0;
    endfunction
    // Reference decode of all seven pins
    function [20:0] mdl(input [18:0] s);
        mdl = {s[18] ? 3'h4 : s[17] ? 3'h2 : {2'h0, s[11]},
            s[18] ? 3'h4 : s[16] ? 3'h3 : {2'h0, s[10]},
            s[15] ? 3'h2 : s[14] ? 3'h3 : (s[13] | s[12]) ? 3'h2 : {2'h0, s[9]},
            s[8] ? (s[7] ? 3'h5 : 3'h3) : {2'h0, s[7]},
            pb(s[6], s[3:0], 4'h6), pb(s[5], s[3:0], 4'h5), pb(s[4], s[3:0], 4'h4)};
    endfunction
    // Far side drives a pin while it is an input or an I2C line
    function [6:0] drv(input [20:0] f);
        integer k;
        begin
            for (k = 0; k < 7; k = k + 1)
                drv[k] = (f[3*k +: 3] == 3'h0) || (f[3*k +: 3] == 3'h3)
                    || (f[3*k +: 3] == 3'h4);
        end
    endfunction
    task chk(input [20:0] e);
        begin
            num_checks = num_checks + 1;
            if (o !== e) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t codes %h expected %h", $time, o, e);
            end
            num_checks = num_checks + 1;
            if (ext !== drv(e)) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t far drive %h expected %h", $time, ext, drv(e));
            end
        end
    endtask
    task complete_run;
        begin
            if (err_count == 0 && num_checks > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    // Watchdog
    initial begin
        #(3000 * 25);
        err_count = err_count + 1;
        complete_run;
    end
    // Random selects every cycle for 2000 cycles, then a reset near the end, a check of the reset codes and one last check
    initial begin
        rnd = $urandom(32'h9A80);
        v = rnd[18:0];
        repeat (16) @(negedge clk_i);
        reset_n = 1;
        repeat (2000) begin
            @(negedge clk_i);
            chk(mdl(v));
            rnd = $urandom;
            v = rnd[18:0];
        end
        reset_n = 0;
        @(negedge clk_i);
        chk(21'h0);
        reset_n = 1;
        @(negedge clk_i);
        chk(mdl(v));
        complete_run;
    end
endmodule // ppfs_top_tb
